//--- logic/afbt_host.sv
// Purpose: Host controller pacing an asynchronous parallel flash bus
// Assumes: Flash inputs synchronous to clk_sys; one command at a time
// Notes: Software issues commands through a small register port
//
// The plain strobed port and the register addresses were left to the implementer.
`timescale 1ns/1ps
module afbt_host import afbt_pkg::*; #(
  parameter int READY_LONG_CYC = C_READY_LONG
) (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire afbt_sw_req_t sw_req,
  output logic [31:0] sw_rdata,
  output logic irq,
  output afbt_pins_t flash_pins,
  input wire logic [15:0] flash_dq_in,
  input wire logic ready_busy_n
);

  afbt_state_t q;
  afbt_state_t next_q;

  assign sw_rdata = q.rdata;
  assign irq = q.irq;
  assign flash_pins = q.pins;

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    logic [2:0] ev;
    logic [2:0] clr;
    logic [12:0] cyc;
    logic [12:0] hold;
    afbt_cmd_t cmd;
    afbt_mode_t mode;
    logic refuse;
    ev = '0;
    clr = '0;
    cyc = q.grade ? C_SLOW : C_FAST;
    hold = '0;
    cmd = afbt_cmd_t'(sw_req.wdata[CMD_LSB +: 3]);
    mode = afbt_mode_t'(sw_req.wdata[MODE_LSB +: 2]);
    refuse = 1'b0;
    next_q = q;
    next_q.rdata = '0;

    // Poll delay runs only while programming is not suspended early
    if (q.poll_pend && !q.susp_early) begin
      if (q.poll_cnt == '0) begin
        next_q.poll_pend = 1'b0;
        ev[IRQ_POLL_OK] = 1'b1;
      end else begin
        next_q.poll_cnt = q.poll_cnt - 13'h0001;
      end
    end

    unique case (q.st)
      ST_IDLE: begin
      end
      ST_RD: begin
        next_q.cnt = q.cnt + 13'h0001;
        if (q.cnt == cyc) begin
          next_q.rd_last = flash_dq_in;
          // Compare against the previous read to expose toggling
          next_q.tog_status = flash_dq_in[STATUS_TOG_POS] ^
            q.rd_last[STATUS_TOG_POS];
          next_q.tog_erase = flash_dq_in[ERASE_TOG_POS] ^
            q.rd_last[ERASE_TOG_POS];
          next_q.pins.ce_n = 1'b1;
          next_q.pins.oe_n = 1'b1;
          next_q.st = ST_IDLE;
          ev[IRQ_DONE] = 1'b1;
        end
      end
      ST_WR: begin
        next_q.cnt = q.cnt + 13'h0001;
        if (q.cnt == C_WP - 13'h0001) begin
          next_q.pins.we_n = 1'b1;
        end
        // Whole write cycle time spent here keeps writes spaced
        if (q.cnt == cyc - 13'h0001) begin
          next_q.pins.ce_n = 1'b1;
          next_q.pins.dq_oe = 1'b0;
          next_q.st = ST_IDLE;
          ev[IRQ_DONE] = 1'b1;
          if (q.last_wr) begin
            next_q.poll_pend = 1'b1;
            next_q.poll_cnt = C_POLL;
            next_q.last_wr = 1'b0;
          end
        end
      end
      ST_RST_LOW: begin
        next_q.cnt = q.cnt + 13'h0001;
        // Worst-case ready time depends on whether an algorithm ran
        hold = q.long_rdy ? 13'(READY_LONG_CYC) : C_RP;
        if (q.cnt == hold - 13'h0001) begin
          next_q.pins.rst_n = 1'b1;
          next_q.st = ST_RST_WAIT;
          next_q.cnt = '0;
        end
      end
      ST_RST_WAIT: begin
        next_q.cnt = q.cnt + 13'h0001;
        if (q.cnt == C_RH - 13'h0001) begin
          next_q.st = ST_IDLE;
          ev[IRQ_DONE] = 1'b1;
        end
      end
      ST_HV: begin
        next_q.cnt = q.cnt + 13'h0001;
        // Writes stay blocked until the elevated level has settled
        if (q.cnt == C_RSP - 13'h0001) begin
          next_q.st = ST_IDLE;
          ev[IRQ_DONE] = 1'b1;
        end
      end
      default: begin
        next_q.st = ST_IDLE;
      end
    endcase

    // ----------------------------------------
    // Software port
    // ----------------------------------------
    if (sw_req.rd) begin
      unique case (sw_req.addr)
        REG_ADDR: next_q.rdata = {12'h000, q.op_addr};
        REG_WDATA: next_q.rdata = {16'h0000, q.op_data};
        REG_RDATA: next_q.rdata = {16'h0000, q.rd_last};
        REG_STATUS: next_q.rdata = {24'h00_0000, q.grade, q.tog_erase,
          q.tog_status, q.pins.hv, q.susp, q.poll_pend, ready_busy_n,
          q.st != ST_IDLE};
        REG_IRQ_STAT: next_q.rdata = {29'h0000_0000, q.irq_st};
        REG_IRQ_MASK: next_q.rdata = {29'h0000_0000, q.irq_mask};
        REG_CONFIG: next_q.rdata = {31'h0000_0000, q.grade};
        default: next_q.rdata = '0;
      endcase
    end

    if (sw_req.wr) begin
      unique case (sw_req.addr)
        REG_ADDR: next_q.op_addr = sw_req.wdata[19:0];
        REG_WDATA: next_q.op_data = sw_req.wdata[15:0];
        REG_IRQ_STAT: clr = sw_req.wdata[2:0];
        REG_IRQ_MASK: next_q.irq_mask = sw_req.wdata[2:0];
        REG_CONFIG: next_q.grade = sw_req.wdata[0];
        default: begin
        end
      endcase
    end

    if (sw_req.wr && sw_req.addr == REG_CMD) begin
      // Write, last program and CMD_HV_ON are refused while the device is busy, reads only during an unsuspended poll delay;
      // ready_busy_n may lag the last program write, so the pending
      // poll delay, unless suspended, also counts as busy
      if (q.st != ST_IDLE) begin
        refuse = 1'b1;
      end else if ((!ready_busy_n || (q.poll_pend && !q.susp)) &&
        (cmd == CMD_WRITE || cmd == CMD_PROG_LAST ||
         cmd == CMD_HV_ON)) begin
        refuse = 1'b1;
      end else if (cmd == CMD_READ && q.poll_pend && !q.susp) begin
        refuse = 1'b1;
      end

      if (refuse) begin
        ev[IRQ_REFUSED] = 1'b1;
      end else begin
        next_q.pins.addr = q.op_addr;
        if (mode == MODE_PROTECT) begin
          next_q.pins.addr[ADDR_BIT6_POS] = 1'b0;
          next_q.pins.addr[ADDR_BIT1_POS] = 1'b1;
          next_q.pins.addr[ADDR_BIT0_POS] = 1'b0;
        end else if (mode == MODE_UNPROTECT) begin
          next_q.pins.addr[ADDR_BIT6_POS] = 1'b1;
          next_q.pins.addr[ADDR_BIT1_POS] = 1'b1;
          next_q.pins.addr[ADDR_BIT0_POS] = 1'b0;
        end
        next_q.cnt = '0;
        unique case (cmd)
          CMD_READ: begin
            next_q.st = ST_RD;
            next_q.pins.ce_n = 1'b0;
            next_q.pins.oe_n = 1'b0;
          end
          CMD_WRITE, CMD_PROG_LAST, CMD_SUSPEND, CMD_RESUME: begin
            // No recovery gap needed after a read
            next_q.st = ST_WR;
            next_q.pins.ce_n = 1'b0;
            next_q.pins.we_n = 1'b0;
            next_q.pins.dq_o = q.op_data;
            next_q.pins.dq_oe = 1'b1;
            next_q.last_wr = (cmd == CMD_PROG_LAST);
            if (cmd == CMD_SUSPEND) begin
              next_q.susp = 1'b1;
              next_q.susp_early = q.poll_pend;
            end
            if (cmd == CMD_RESUME) begin
              next_q.susp = 1'b0;
              next_q.susp_early = 1'b0;
              if (q.susp_early) begin
                next_q.poll_cnt = C_POLL;
              end
            end
          end
          CMD_HW_RESET: begin
            // A long hold also lets the device drop to standby
            next_q.st = ST_RST_LOW;
            next_q.pins.rst_n = 1'b0;
            next_q.pins.hv = 1'b0;
            next_q.long_rdy = !ready_busy_n;
            next_q.poll_pend = 1'b0;
            next_q.susp = 1'b0;
            next_q.susp_early = 1'b0;
          end
          CMD_HV_ON: begin
            next_q.st = ST_HV;
            next_q.pins.hv = 1'b1;
          end
          CMD_HV_OFF: begin
            next_q.pins.hv = 1'b0;
            ev[IRQ_DONE] = 1'b1;
          end
        endcase
      end
    end

    // A new event wins over a clear in the same cycle
    next_q.irq_st = (q.irq_st & ~clr) | ev;
    next_q.irq = |(next_q.irq_st & next_q.irq_mask);
  end

  // ----------------------------------------
  // State register
  // ----------------------------------------
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      q <= '0;
      q.st <= ST_IDLE;
      q.pins.ce_n <= 1'b1;
      q.pins.oe_n <= 1'b1;
      q.pins.we_n <= 1'b1;
      q.pins.rst_n <= 1'b1;
    end else begin
      q <= next_q;
    end
  end

endmodule

//--- logic/afbt_pkg.sv
// Purpose: Constants and types for the async flash bus host controller
// Assumes: 250 MHz clk_sys; flash pins sampled as synchronous inputs
// Notes: Times are kept in ns; cycle counts derive from the clock period
package afbt_pkg;

  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int T_CLK_NS = 4;
  localparam int T_FAST_NS = 90;
  localparam int T_SLOW_NS = 100;
  localparam int T_WP_NS = 35;
  localparam int T_RP_NS = 500;
  localparam int T_RH_NS = 50;
  localparam int T_POLL_NS = 4000;
  localparam int T_RSP_NS = 4000;
  localparam int T_READY_LONG_NS = 20000;

  localparam logic [12:0] C_FAST = 13'((T_FAST_NS + T_CLK_NS - 1) / T_CLK_NS);
  localparam logic [12:0] C_SLOW = 13'((T_SLOW_NS + T_CLK_NS - 1) / T_CLK_NS);
  localparam logic [12:0] C_WP = 13'((T_WP_NS + T_CLK_NS - 1) / T_CLK_NS);
  localparam logic [12:0] C_RP = 13'((T_RP_NS + T_CLK_NS - 1) / T_CLK_NS);
  localparam logic [12:0] C_RH = 13'((T_RH_NS + T_CLK_NS - 1) / T_CLK_NS);
  localparam logic [12:0] C_POLL =
    13'((T_POLL_NS + T_CLK_NS - 1) / T_CLK_NS);
  localparam logic [12:0] C_RSP = 13'((T_RSP_NS + T_CLK_NS - 1) / T_CLK_NS);
  localparam int C_READY_LONG = (T_READY_LONG_NS + T_CLK_NS - 1) / T_CLK_NS;

  // ----------------------------------------
  // Register map and fields
  // ----------------------------------------
  localparam logic [4:0] REG_CMD = 5'h00;
  localparam logic [4:0] REG_ADDR = 5'h04;
  localparam logic [4:0] REG_WDATA = 5'h08;
  localparam logic [4:0] REG_RDATA = 5'h0C;
  localparam logic [4:0] REG_STATUS = 5'h10;
  localparam logic [4:0] REG_IRQ_STAT = 5'h14;
  localparam logic [4:0] REG_IRQ_MASK = 5'h18;
  localparam logic [4:0] REG_CONFIG = 5'h1C;

  localparam int CMD_LSB = 0;
  localparam int MODE_LSB = 3;
  localparam int IRQ_DONE = 0;
  localparam int IRQ_REFUSED = 1;
  localparam int IRQ_POLL_OK = 2;
  localparam int ERASE_TOG_POS = 2;
  localparam int STATUS_TOG_POS = 6;
  localparam int ADDR_BIT0_POS = 0;
  localparam int ADDR_BIT1_POS = 1;
  localparam int ADDR_BIT6_POS = 6;

  typedef enum logic [2:0] {
    CMD_READ = 3'h0,
    CMD_WRITE = 3'h1,
    CMD_PROG_LAST = 3'h2,
    CMD_SUSPEND = 3'h3,
    CMD_RESUME = 3'h4,
    CMD_HW_RESET = 3'h5,
    CMD_HV_ON = 3'h6,
    CMD_HV_OFF = 3'h7
  } afbt_cmd_t;

  typedef enum logic [1:0] {
    MODE_PLAIN = 2'h0,
    MODE_PROTECT = 2'h1,
    MODE_UNPROTECT = 2'h2,
    MODE_SPARE = 2'h3
  } afbt_mode_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_RD = 3'h1,
    ST_WR = 3'h2,
    ST_RST_LOW = 3'h3,
    ST_RST_WAIT = 3'h4,
    ST_HV = 3'h5
  } afbt_st_t;

  // Flash pin drive
  typedef struct packed {
    logic [19:0] addr;
    logic [15:0] dq_o;
    logic dq_oe;
    logic ce_n;
    logic oe_n;
    logic we_n;
    logic rst_n;
    logic hv;
  } afbt_pins_t;

  // Software register port
  typedef struct packed {
    logic [4:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } afbt_sw_req_t;

  typedef struct packed {
    afbt_st_t st;
    logic [12:0] cnt;
    logic [12:0] poll_cnt;
    logic poll_pend;
    logic susp;
    logic susp_early;
    logic long_rdy;
    logic last_wr;
    logic grade;
    logic [19:0] op_addr;
    logic [15:0] op_data;
    logic [15:0] rd_last;
    logic tog_status;
    logic tog_erase;
    logic [2:0] irq_st;
    logic [2:0] irq_mask;
    logic [31:0] rdata;
    logic irq;
    afbt_pins_t pins;
  } afbt_state_t;

endpackage

//--- tb/afbt_sva.sv
// Purpose: Port checks on the flash host controller
// Assumes: One clock, synchronous active-low reset
// Notes: Counters stand in for waits too long to repeat
`timescale 1ns/1ps
module afbt_sva import afbt_pkg::*; (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire afbt_sw_req_t sw_req,
  input wire logic [31:0] sw_rdata,
  input wire logic irq,
  input wire afbt_pins_t flash_pins,
  input wire logic [15:0] flash_dq_in,
  input wire logic ready_busy_n
);
  // ----------------------------------------
  // Cycles since pin events
  // ----------------------------------------
  logic [11:0] gap, rh, hvc;
  logic cmd_wr;
  function automatic logic [11:0] sat(input logic [11:0] x);
    return x + {11'h000, x != 12'hFFF};
  endfunction
  assign cmd_wr = sw_req.wr && sw_req.addr == REG_CMD;
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      gap <= 12'hFFF;
      rh <= 12'hFFF;
      hvc <= 12'hFFF;
    end else begin
      gap <= $fell(flash_pins.we_n) ? 12'h000 : sat(gap);
      rh <= $rose(flash_pins.rst_n) ? 12'h000 : sat(rh);
      hvc <= $rose(flash_pins.hv) ? 12'h000 : sat(hvc);
    end
  end
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  protect_addr_a: assert property (cmd_wr && sw_req.wdata[4:3] == 2'h1
    |=> flash_pins.ce_n || flash_pins.addr[6:0] ==? 7'b0xxxx10)
    else $error("protect address bits wrong");
  unprotect_addr_a: assert property (cmd_wr && sw_req.wdata[4:3] == 2'h2
    |=> flash_pins.ce_n || flash_pins.addr[6:0] ==? 7'b1xxxx10)
    else $error("unprotect address bits wrong");
  write_gap_a: assert property ($fell(flash_pins.we_n)
    |-> gap >= 12'h016)
    else $error("write cycles too close");
  reset_high_a: assert property ($fell(flash_pins.ce_n)
    |-> rh >= 12'h00C)
    else $error("access too soon after reset");
  hv_setup_a: assert property ($fell(flash_pins.we_n) && flash_pins.hv
    |-> hvc >= 12'h3E7)
    else $error("write too soon after elevated level");
  no_overlap_a: assert property (!flash_pins.we_n
    |-> flash_pins.oe_n)
    else $error("write strobe during output enable");
  busy_refuse_a: assert property (cmd_wr && !ready_busy_n
    && sw_req.wdata[2:0] == CMD_WRITE |=> flash_pins.we_n [*3])
    else $error("write issued while device busy");
  read_hold_a: assert property ($fell(flash_pins.oe_n)
    |-> ##22 !flash_pins.oe_n)
    else $error("read strobe too short");
endmodule

//--- tb/afbt_flash_model.sv
// Purpose: Behavioural flash device on the controller's far side
// Assumes: Pins sampled on clk_sys; any write while ready starts a program
// Notes: Undriven data lines show a pattern changing every cycle
`timescale 1ns/1ps
module afbt_flash_model import afbt_pkg::*; #(
  parameter int ACC_CYC = 22,
  parameter int PROG_CYC = 60
) (
  input wire logic clk_sys,
  input wire afbt_pins_t flash_pins,
  output logic [15:0] flash_dq_in,
  output logic ready_busy_n
);
  // ----------------------------------------
  // Device state
  // ----------------------------------------
  logic [15:0] last = 16'h0000;
  logic [15:0] stat = 16'h0000;
  int busy = 0;
  int rd_cnt = 0;
  int low_cnt = 0;
  logic standby = 1'b0;
  logic rd;
  assign rd = !flash_pins.ce_n && !flash_pins.oe_n;
  assign ready_busy_n = busy == 0;
  always_comb begin
    // A device parked in standby leaves the data lines undriven
    if (rd && rd_cnt >= ACC_CYC && !standby)
      flash_dq_in = busy != 0 ? stat
        : flash_pins.addr[15:0] ^ 16'h5A5A;
    else
      flash_dq_in = ~last;
  end
  always @(posedge clk_sys) begin
    last <= flash_dq_in;
    rd_cnt <= rd ? rd_cnt + 1 : 0;
    standby <= low_cnt >= 5000;
    if (!flash_pins.rst_n) begin
      busy <= 0;
      low_cnt <= low_cnt + 1;
    end else begin
      low_cnt <= 0;
      if ($fell(flash_pins.we_n) && busy == 0)
        busy <= PROG_CYC;
      else if (busy != 0)
        busy <= busy - 1;
      if (busy != 0 && $rose(flash_pins.ce_n | flash_pins.oe_n)) begin
        stat[6] <= ~stat[6];
        stat[2] <= stat[2] ^ (flash_pins.addr[19:16] == 4'h0);
      end
    end
  end
endmodule

//--- tb/testbench.sv
// Purpose: Self-checking bench for the flash host controller
// Assumes: Behavioural flash model on the far side
// Notes: Long reset wait shortened through READY_LONG_CYC
`timescale 1ns/1ps
module testbench import afbt_pkg::*;;
  logic clk_sys = 1'b0;
  logic nrst = 1'b0;
  afbt_sw_req_t sw_req = '0;
  logic [31:0] sw_rdata;
  logic irq;
  afbt_pins_t flash_pins;
  logic [15:0] flash_dq_in;
  logic ready_busy_n;
  int n_fail = 0;
  int n_checks = 0;
  logic [31:0] d;
  // Address, mode, expected array word
  logic [37:0] rows [6] = '{{20'h0_00FF, 2'h0, 16'h5AA5},
    {20'h0_00FF, 2'h1, 16'h5AE4}, {20'h0_00FF, 2'h2, 16'h5AA4},
    {20'h0_0000, 2'h0, 16'h5A5A}, {20'h0_0000, 2'h1, 16'h5A58},
    {20'h0_0000, 2'h2, 16'h5A18}};
  initial forever #2 clk_sys = ~clk_sys;
  afbt_host #(.READY_LONG_CYC(50)) afbt_host_inst (.clk_sys(clk_sys),
    .nrst(nrst), .sw_req(sw_req), .sw_rdata(sw_rdata), .irq(irq),
    .flash_pins(flash_pins), .flash_dq_in(flash_dq_in),
    .ready_busy_n(ready_busy_n));
  // Long program time keeps the device busy across the toggle reads
  afbt_flash_model #(.PROG_CYC(200)) afbt_flash_model_inst (
    .clk_sys(clk_sys),
    .flash_pins(flash_pins), .flash_dq_in(flash_dq_in),
    .ready_busy_n(ready_busy_n));
  // ----------------------------------------
  // Bus and checking tasks
  // ----------------------------------------
  task automatic check(input string what, input logic [31:0] e,
      input logic [31:0] got);
    n_checks++;
    if (got !== e) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", what, e, got);
    end
  endtask
  task automatic wr_reg(input logic [4:0] a, input logic [31:0] v);
    @(posedge clk_sys);
    sw_req <= '{a, v, 1'b1, 1'b0};
    @(posedge clk_sys);
    sw_req <= '0;
  endtask
  task automatic rd_reg(input logic [4:0] a);
    @(posedge clk_sys);
    sw_req <= '{a, 32'h0000_0000, 1'b0, 1'b1};
    @(posedge clk_sys);
    sw_req <= '0;
    #1 d = sw_rdata;
  endtask
  task automatic wait_irq();
    int k;
    k = 0;
    // Look past the edge that may still be updating irq
    #1;
    while (irq !== 1'b1 && k < 6000) begin
      @(posedge clk_sys);
      #1 k++;
    end
    check("irq", 32'h1, {31'h0, irq});
    wr_reg(REG_IRQ_STAT, 32'h7);
  endtask
  task automatic op(input logic [2:0] c, input logic [1:0] m);
    wr_reg(REG_CMD, {27'h0, m, c});
    wait_irq();
  endtask
  task automatic do_read(input logic [19:0] a, input logic [1:0] m,
      input logic [15:0] e);
    wr_reg(REG_ADDR, {12'h000, a});
    op(CMD_READ, m);
    rd_reg(REG_RDATA);
    check("read data", {16'h0000, e}, d);
  endtask
  task automatic finish_test();
    $display("checks %0d failures %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  initial begin
    #100000;
    n_fail++;
    finish_test();
  end
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    repeat (3) @(posedge clk_sys);
    nrst <= 1'b1;
    @(posedge clk_sys);
    #1 check("idle pins", 32'h78, {25'h0, flash_pins.ce_n,
      flash_pins.oe_n, flash_pins.we_n, flash_pins.rst_n,
      flash_pins.dq_oe, flash_pins.hv, irq});
    wr_reg(REG_IRQ_MASK, 32'h1);
    foreach (rows[i]) begin
      do_read(rows[i][37:18], rows[i][17:16], rows[i][15:0]);
    end
    op(CMD_WRITE, 2'h0);
    wr_reg(REG_CMD, {27'h0, 2'h0, CMD_WRITE});
    rd_reg(REG_IRQ_STAT);
    check("refused write", 32'h2, d);
    check("masked irq", 32'h0, {31'h0, irq});
    // Two status reads in sector zero while busy: both bits flip
    do_read(20'h0_0000, 2'h0, 16'h0000);
    do_read(20'h0_0000, 2'h0, 16'h0044);
    rd_reg(REG_STATUS);
    check("toggle bits", 32'h60, d & 32'h60);
    op(CMD_HW_RESET, 2'h0);
    rd_reg(REG_STATUS);
    check("ready after reset", 32'h2, d & 32'h2);
    do_read(20'h0_00FF, 2'h0, 16'h5AA5);
    op(CMD_HV_ON, 2'h0);
    wr_reg(REG_WDATA, 32'h0000_C3C3);
    wr_reg(REG_CMD, {27'h0, 2'h0, CMD_WRITE});
    #1 check("write pins", 32'h0001_C3C3,
      {15'h0, flash_pins.dq_oe, flash_pins.dq_o});
    wait_irq();
    rd_reg(REG_STATUS);
    check("elevated level", 32'h10, d & 32'h10);
    op(CMD_HV_OFF, 2'h0);
    repeat (200) @(posedge clk_sys);
    op(CMD_PROG_LAST, 2'h0);
    op(CMD_SUSPEND, 2'h0);
    op(CMD_RESUME, 2'h0);
    rd_reg(REG_STATUS);
    check("poll pending", 32'h4, d & 32'h4);
    wr_reg(REG_CMD, {27'h0, 2'h0, CMD_READ});
    rd_reg(REG_IRQ_STAT);
    check("refused poll read", 32'h2, d);
    wr_reg(REG_IRQ_MASK, 32'h4);
    wait_irq();
    wr_reg(REG_IRQ_MASK, 32'h1);
    wr_reg(REG_CONFIG, 32'h1);
    do_read(20'h0_00FF, 2'h0, 16'h5AA5);
    rd_reg(REG_STATUS);
    check("slow grade", 32'h80, d & 32'h80);
    op(CMD_HW_RESET, 2'h0);
    rd_reg(REG_STATUS);
    check("ready after short reset", 32'h2, d & 32'h2);
    @(posedge clk_sys);
    nrst <= 1'b0;
    repeat (3) @(posedge clk_sys);
    nrst <= 1'b1;
    rd_reg(REG_CONFIG);
    check("config after reset", 32'h0, d);
    rd_reg(5'h02);
    check("unmapped", 32'h0, d);
    finish_test();
  end
endmodule
bind afbt_host afbt_sva afbt_sva_inst (.clk_sys(clk_sys), .nrst(nrst),
  .sw_req(sw_req), .sw_rdata(sw_rdata), .irq(irq),
  .flash_pins(flash_pins), .flash_dq_in(flash_dq_in),
  .ready_busy_n(ready_busy_n));
